// file: src/dts_pkg.sv
// Package for the debug trigger and run status block.
// Assumes a 32-bit Avalon-MM slave port with 8-bit registers in the low byte lane.
package dts_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_TRIG_CFG = 5'h00;
  localparam logic [4:0] OFS_RUN_STAT = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_FIFO_HI = 5'h0c;
  localparam logic [4:0] OFS_FIFO_LO = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
  // Field positions
  localparam int CFG_QUAL_BIT = 7;
  localparam int CFG_BEGIN_BIT = 6;
  localparam int STAT_AF_BIT = 7;
  localparam int STAT_BF_BIT = 6;
  localparam int STAT_ARMED_STATUS_FLAG_BIT = 5;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_ARM_BIT = 6;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TRIG_BIT = 1;
  // Writable config bits: 4 and 5 are hard-wired low
  localparam logic [7:0] CFG_WMASK = 8'hcf;
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [5:0] CTRL_LOW_RST = 6'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // Trace storage geometry
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL_CNT = 4'h8;
  // Trigger mode codes
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVT_B = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EVT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B = 4'h5;
  localparam logic [3:0] MODE_A_NOT_B = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;
  // Run sequencing states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FILL, ST_CIRC} dts_state_t;
  // Event-only modes store one byte per event and always begin-trace
  function automatic logic dts_event_only(input logic [3:0] m);
    return (m == MODE_EVT_B) || (m == MODE_A_THEN_EVT_B);
  endfunction : dts_event_only
endpackage : dts_pkg

// file: src/dts_trig_if.sv
// Interface between run control and the trigger evaluator.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface dts_trig_if;
  logic [3:0] mode; // Trigger mode field
  logic qual; // Opcode qualification select
  logic a_raw; // Comparator A hit
  logic b_raw; // Comparator B hit
  logic a_exec; // Opcode at A executed
  logic b_exec; // Opcode at B executed
  logic bus_valid; // CPU bus access this cycle
  logic [15:0] addr; // CPU bus address
  logic [15:0] cmp_a; // Comparator A value
  logic [15:0] cmp_b; // Comparator B value
  logic run_start; // A run begins
  logic armed; // Run in progress
  logic qa; // Qualified A match
  logic qb; // Qualified B match
  logic trig; // Trigger event
  logic a_seen; // A matched in this run
  modport ctrl (output mode, qual, a_raw, b_raw, a_exec, b_exec, bus_valid, addr,
    cmp_a, cmp_b, run_start, armed, input qa, qb, trig, a_seen);
  modport eval (input mode, qual, a_raw, b_raw, a_exec, b_exec, bus_valid, addr,
    cmp_a, cmp_b, run_start, armed, output qa, qb, trig, a_seen);
endinterface : dts_trig_if

// file: src/dts_trig_eval.sv
// Trigger evaluator: qualifies comparator hits and decodes the trigger mode.
// Assumes comparator hits and opcode confirmations are synchronous to core_clk.
`timescale 1ns/1ps
module dts_trig_eval (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Trigger link
  dts_trig_if.eval t
);
  import dts_pkg::*;
  // Qualified matches: tag type waits for execution, force type does not
  wire qa_w = t.qual ? t.a_exec : t.a_raw; // RULE2
  wire qb_w = t.qual ? t.b_exec : t.b_raw; // RULE2
  // Sequential modes need A first
  wire seq_mode = (t.mode == MODE_A_THEN_B) || (t.mode == MODE_A_THEN_EVT_B);
  wire b_eff = seq_mode ? (qb_w & t.a_seen) : qb_w; // RULE18
  // Range compares only count on a real bus cycle
  wire in_rng = t.bus_valid && (t.addr >= t.cmp_a) && (t.addr <= t.cmp_b);
  wire out_rng = t.bus_valid && ((t.addr < t.cmp_a) || (t.addr > t.cmp_b));
  logic a_seen_q;
  logic trig_w;
  // Mode decode
  always_comb begin
    case (t.mode) // RULE5
      MODE_A_ONLY: trig_w = qa_w;
      MODE_A_OR_B: trig_w = qa_w | qb_w;
      MODE_A_THEN_B: trig_w = b_eff;
      MODE_EVT_B: trig_w = qb_w;
      MODE_A_THEN_EVT_B: trig_w = b_eff;
      MODE_A_AND_B: trig_w = qa_w & qb_w;
      MODE_A_NOT_B: trig_w = qa_w & ~qb_w;
      MODE_INSIDE: trig_w = in_rng; // RULE6
      MODE_OUTSIDE: trig_w = out_rng; // RULE6
      default: trig_w = 1'b0;
    endcase
  end
  // Remember an A match for the sequential modes; cleared per run
  always_ff @(posedge core_clk) begin
    if (srst || t.run_start) begin
      a_seen_q <= 1'b0;
    end else if (t.armed && qa_w) begin
      a_seen_q <= 1'b1; // RULE18
    end
  end
  assign t.qa = qa_w;
  assign t.qb = b_eff;
  assign t.trig = trig_w;
  assign t.a_seen = a_seen_q;
  // A B event in sequential modes never counts before an A match
  chk_seq_b_after_a: assert property (@(posedge core_clk) disable iff (srst) // RULE18
    (seq_mode && t.trig) |-> t.a_seen) else $error("B counted before A");
  // Tag type ignores a raw hit that did not execute
  chk_tag_qualify: assert property (@(posedge core_clk) disable iff (srst) // RULE2
    (t.qual && t.mode == MODE_A_ONLY && !t.a_exec) |-> !t.trig)
    else $error("tag trigger without execution");
endmodule : dts_trig_eval

// file: src/dts_trace_ctrl.sv
// Debug trace trigger, run control, status and trace FIFO, Avalon-MM slave.
// Assumes all bus-monitor inputs come from logic on core_clk.
// Functional notes
// RULE1 - Config writable only unarmed; bits 4,5 zero
// RULE2 - Tag type needs executed opcode to trigger
// RULE3 - Begin bit selects end or begin trace
// RULE4 - Event-only modes always run as begin trace
// RULE5 - Mode field decodes nine trigger modes
// RULE6 - Modes 7, 8 compare address range
// RULE7 - Status register ignores writes
// RULE8 - A flag cleared at start, set on A
// RULE9 - B flag cleared at start, set on B
// RULE10 - Armed flag mirrors arm while enabled
// RULE11 - Run ends on full or end trigger
// RULE12 - Writing zero arm or enable stops run
// RULE13 - Valid count cleared at start, holds words
// RULE14 - Reading FIFO never decrements valid count
// RULE15 - Host tracks its own FIFO read count
// RULE16 - High read holds, low read advances FIFO
// RULE17 - Event-only stores low byte, high reads zero
// RULE18 - Sequential B counts only after A
// RULE19 - FIFO holds eight words, full at eight
`timescale 1ns/1ps
module dts_trace_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CPU bus monitor
  input wire logic bus_valid,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] cmp_a_addr,
  input wire logic [15:0] cmp_b_addr,
  input wire logic cmp_a_hit,
  input wire logic cmp_b_hit,
  input wire logic opc_a_exec,
  input wire logic opc_b_exec,
  // Capture data
  input wire logic cap_valid,
  input wire logic [15:0] cap_data,
  // Status outputs
  output logic trace_armed,
  output logic irq
);
  import dts_pkg::*;
  dts_trig_if tif ();
  dts_trig_eval u_eval (
    .core_clk(core_clk),
    .srst(srst),
    .t(tif)
  );
  // Registers
  logic [7:0] trace_trigger_config; // Mode, begin and qualify
  logic trace_module_enable; // Module enable
  logic [5:0] ctrl_low; // Break and R/W options, stored only
  dts_state_t state; // Run sequencing
  logic match_a_flag;
  logic match_b_flag;
  logic [3:0] valid_word_count;
  logic [2:0] wr_ptr; // Next slot to write
  logic [2:0] rd_ptr; // Next word to read out
  logic [15:0] fifo_mem [FIFO_DEPTH]; // Trace words
  logic [1:0] irq_stat; // Sticky events
  logic [1:0] irq_mask;
  // Bus handshake: one wait cycle, then a one-cycle acknowledge
  wire req = avs_read | avs_write;
  wire commit = req & ~avs_waitrequest;
  wire wr_go = commit & avs_write & avs_byteenable[0];
  wire rd_go = commit & avs_read;
  wire wr_cfg = wr_go && avs_address == OFS_TRIG_CFG;
  wire wr_ctrl = wr_go && avs_address == OFS_CTRL;
  wire wr_istat = wr_go && avs_address == OFS_IRQ_STAT;
  wire wr_imask = wr_go && avs_address == OFS_IRQ_MASK;
  wire rd_lo = rd_go && avs_address == OFS_FIFO_LO;
  // Configuration fields
  wire [3:0] mode = trace_trigger_config[3:0];
  wire ev_only = dts_event_only(mode);
  wire begin_eff = trace_trigger_config[CFG_BEGIN_BIT] | ev_only; // RULE4
  wire armed = state != ST_IDLE;
  // Software run control
  wire new_en = avs_writedata[CTRL_EN_BIT];
  wire new_arm = avs_writedata[CTRL_ARM_BIT];
  wire run_start = wr_ctrl & new_en & new_arm & ~armed; // RULE10
  wire sw_stop = wr_ctrl & armed & ~(new_en & new_arm); // RULE12
  // Store strobe per state
  wire store = (state == ST_CIRC && cap_valid) ||
    (state == ST_FILL && (ev_only ? tif.trig : cap_valid)); // RULE3
  wire [15:0] store_word = ev_only ? {8'h00, cap_data[7:0]} : cap_data; // RULE17
  wire [2:0] next_wr = store ? wr_ptr + 3'h1 : wr_ptr;
  wire [3:0] next_cnt = (store && valid_word_count != FIFO_FULL_CNT) ?
    valid_word_count + 4'h1 : valid_word_count;
  // Hardware run end
  wire full_end = state == ST_FILL && next_cnt == FIFO_FULL_CNT; // RULE11 RULE19
  wire trig_end = state == ST_CIRC && tif.trig; // RULE11
  wire hw_end = full_end | trig_end;
  wire run_end = armed & (hw_end | sw_stop);
  // Oldest word after a wrapped end trace sits at the write pointer
  wire [2:0] end_rd = (state == ST_CIRC && next_cnt == FIFO_FULL_CNT) ? next_wr : 3'h0;
  wire [1:0] irq_ev = {armed & tif.trig, run_end};
  wire [7:0] stat_val = {match_a_flag, match_b_flag, armed, 1'b0, valid_word_count};
  wire [15:0] rd_word = fifo_mem[rd_ptr];
  // Read multiplexer; unmapped offsets read zero
  logic [7:0] rd_byte;
  always_comb begin
    case (avs_address)
      OFS_TRIG_CFG: rd_byte = trace_trigger_config & CFG_WMASK; // RULE1
      OFS_RUN_STAT: rd_byte = stat_val;
      OFS_CTRL: rd_byte = {trace_module_enable, armed, ctrl_low};
      OFS_FIFO_HI: rd_byte = rd_word[15:8]; // RULE17
      OFS_FIFO_LO: rd_byte = rd_word[7:0];
      OFS_IRQ_STAT: rd_byte = {6'h00, irq_stat};
      OFS_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end
  // Trigger evaluator hookup
  assign tif.mode = mode;
  assign tif.qual = trace_trigger_config[CFG_QUAL_BIT];
  assign tif.a_raw = cmp_a_hit;
  assign tif.b_raw = cmp_b_hit;
  assign tif.a_exec = opc_a_exec;
  assign tif.b_exec = opc_b_exec;
  assign tif.bus_valid = bus_valid;
  assign tif.addr = bus_addr;
  assign tif.cmp_a = cmp_a_addr;
  assign tif.cmp_b = cmp_b_addr;
  assign tif.run_start = run_start;
  assign tif.armed = armed;
  // Bus slave: waitrequest drops for one cycle, readdata loaded with it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end
  // Trigger configuration; locked while armed, status has no write path
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trace_trigger_config <= CFG_RST;
    end else if (wr_cfg && !armed) begin
      trace_trigger_config <= avs_writedata[7:0] & CFG_WMASK; // RULE1 RULE7
    end
  end
  // Control register: enable and stored options; arm lives in the state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trace_module_enable <= 1'b0;
      ctrl_low <= CTRL_LOW_RST;
    end else if (wr_ctrl) begin
      trace_module_enable <= new_en;
      ctrl_low <= avs_writedata[5:0];
    end
  end
  // Run sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else if (run_start) begin
      if (ev_only) begin
        state <= ST_FILL; // RULE4
      end else if (begin_eff) begin
        state <= ST_WAIT; // RULE3
      end else begin
        state <= ST_CIRC; // RULE3
      end
    end else if (run_end) begin
      state <= ST_IDLE; // RULE11 RULE12
    end else if (state == ST_WAIT && tif.trig) begin
      state <= ST_FILL; // RULE3
    end
  end
  // Match flags; a new run clears them
  always_ff @(posedge core_clk) begin
    if (srst || run_start) begin
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
    end else if (armed) begin
      match_a_flag <= match_a_flag | tif.qa; // RULE8
      match_b_flag <= match_b_flag | tif.qb; // RULE9
    end
  end
  // Count and pointers; reads move only the read pointer
  always_ff @(posedge core_clk) begin
    if (srst || run_start) begin
      valid_word_count <= 4'h0; // RULE13
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
    end else if (armed) begin
      valid_word_count <= next_cnt; // RULE13 RULE14
      wr_ptr <= next_wr;
      if (run_end) begin
        rd_ptr <= end_rd;
      end
    end else if (rd_lo) begin
      rd_ptr <= rd_ptr + 3'h1; // RULE16
    end
  end
  // Trace storage, no reset needed for data
  always_ff @(posedge core_clk) begin
    if (store) begin
      fifo_mem[wr_ptr] <= store_word; // RULE17
    end
  end
  // Interrupt status: set wins over write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_stat <= IRQ_RST;
      irq_mask <= IRQ_RST;
      irq <= 1'b0;
      trace_armed <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_istat ? avs_writedata[1:0] : 2'h0)) | irq_ev;
      if (wr_imask) begin
        irq_mask <= avs_writedata[1:0];
      end
      irq <= |(irq_stat & irq_mask);
      trace_armed <= armed; // RULE10
    end
  end
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_cfg_write_armed;
    wr_cfg && armed;
  endsequence
  sequence s_start;
    run_start;
  endsequence
  // Config writes while armed are dropped so a run is never reshaped midway
  chk_cfg_locked: assert property (s_cfg_write_armed |=> $stable(trace_trigger_config)) // RULE1
    else $error("config changed while armed");
  // The two unused config bits never hold a one
  chk_cfg_hardwired: assert property (trace_trigger_config[5:4] == 2'h0) // RULE1
    else $error("config bits 5:4 not zero");
  // A status write leaves flags, armed state and count alone
  chk_status_ro: assert property ((wr_go && avs_address == OFS_RUN_STAT && !armed) // RULE7
    |=> $stable(stat_val)) else $error("status changed by write");
  // A new run starts from clean flags and an empty count
  chk_start_clears: assert property (s_start |=> !match_a_flag && !match_b_flag // RULE8 RULE13
    && valid_word_count == 4'h0) else $error("run start did not clear");
  // Matches while armed are remembered until the next run start
  chk_a_flag_set: assert property ((armed && tif.qa) |=> match_a_flag) // RULE8
    else $error("A flag not set");
  chk_b_flag_set: assert property ((armed && tif.qb && !run_start) |=> match_b_flag) // RULE9
    else $error("B flag not set");
  // Armed status follows a run start, the output one cycle later
  chk_arm_mirror: assert property (s_start |=> armed ##1 trace_armed) // RULE10
    else $error("armed flag not raised");
  // An end trace stops at its trigger
  chk_end_trig: assert property (trig_end |=> !armed) // RULE11
    else $error("end trace did not stop");
  // A begin trace stops once the eighth word is in, count left at eight
  chk_full_end: assert property (full_end // RULE11 RULE19
    |=> !armed && valid_word_count == FIFO_FULL_CNT) else $error("full store did not stop");
  // Software stop ends the run in the next cycle
  chk_sw_stop: assert property (sw_stop |=> state == ST_IDLE) // RULE12
    else $error("software stop ignored");
  // A begin trace stores nothing while it waits for its trigger
  chk_wait_no_store: assert property ((state == ST_WAIT) |=> $stable(valid_word_count)) // RULE3
    else $error("stored before begin trigger");
  // Idle time and FIFO reads never move the valid count
  chk_cnt_hold: assert property ((!armed && !run_start) |=> $stable(valid_word_count)) // RULE14
    else $error("count moved while idle");
  chk_cnt_range: assert property (valid_word_count <= FIFO_FULL_CNT) // RULE13
    else $error("count above eight");
  // A high byte read leaves the read pointer where it was
  chk_fifo_hold: assert property ((rd_go && avs_address == OFS_FIFO_HI && !run_end) // RULE16
    |=> $stable(rd_ptr)) else $error("high read moved FIFO");
  // A low byte read on an idle block steps to the next word
  chk_lo_advance: assert property ((rd_lo && !armed) |=> rd_ptr == $past(rd_ptr) + 3'h1) // RULE16
    else $error("low read did not advance");
  // Event-only modes go straight to storing
  chk_evt_begin: assert property ((s_start ##0 ev_only) |=> state == ST_FILL) // RULE4
    else $error("event-only not begin trace");
  // Interrupt output is the registered OR of unmasked sticky events
  chk_irq_level: assert property (1'b1 |=> irq == $past(|(irq_stat & irq_mask)))
    else $error("interrupt level wrong");
endmodule : dts_trace_ctrl

// file: verif/dts_host_model.sv
// Debug host model: an Avalon-MM master that reads and writes the trace registers.
// Assumes the slave answers by dropping waitrequest, all on core_clk.
`timescale 1ns/1ps
module dts_host_model (
  // Clock
  input wire logic core_clk,
  // Avalon-MM master side
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Raised when an answer never came
  output logic hang
);
  import dts_pkg::*;
  int fifo_reads = 0; // Own tally of words taken, the device never counts down
  // Idle bus at time zero
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    hang = 1'b0;
  end
  // One access; entered just after a rising edge and left just after one
  task automatic xfer(input logic wr, input logic [4:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd);
    int n;
    n = 0;
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, wd};
    @(posedge core_clk);
    // Request held until the edge that sees waitrequest low
    while (avs_waitrequest !== 1'b0 && n < 64) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 64) hang <= 1'b1;
    rd = avs_readdata[7:0];
    if (!wr && adr == OFS_FIFO_LO) fifo_reads++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Released lines show a changed value so nothing leans on a stale one
    avs_writedata <= ~{24'h000000, wd};
    // An edge passes so the strobe is never reassigned in one step
    @(posedge core_clk);
  endtask : xfer
  // Register write
  task automatic wr(input logic [4:0] adr, input logic [7:0] wd);
    logic [7:0] dummy;
    xfer(1'b1, adr, wd, dummy);
  endtask : wr
  // Register read
  task automatic rd(input logic [4:0] adr, output logic [7:0] q);
    xfer(1'b0, adr, 8'h00, q);
  endtask : rd
endmodule : dts_host_model

// file: verif/debug_trigger_status_control_tb.sv
// Self-checking bench for the trace trigger and run status block.
// Assumes the host model above and the design sources are compiled first.
`timescale 1ns/1ps
module debug_trigger_status_control_tb;
  import dts_pkg::*;
  // Clock, reset and bus wires
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic hang;
  // CPU bus monitor stimulus
  logic bus_valid = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [15:0] cmp_a_addr = 16'h1000;
  logic [15:0] cmp_b_addr = 16'h2000;
  logic cmp_a_hit = 1'b0;
  logic cmp_b_hit = 1'b0;
  logic opc_a_exec = 1'b0;
  logic opc_b_exec = 1'b0;
  logic cap_valid = 1'b0;
  logic [15:0] cap_data = 16'h0000;
  logic trace_armed;
  logic irq;
  // Bench state and reference model
  int mismatches = 0;
  int check_count = 0;
  int model_q[$]; // Words the store should hold, oldest first
  int seed_v;
  logic [7:0] rv;
  logic [15:0] wv;
  // Step at which each mode ends its run, zero for never
  int ends_at[16] = '{2, 1, 3, 0, 0, 4, 2, 5, 6, 0, 0, 0, 0, 0, 0, 0};
  logic [7:0] step_hits[6] = '{8'h02, 8'h01, 8'h02, 8'h03, 8'h10, 8'h10};
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  dts_trace_ctrl uut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_valid(bus_valid), .bus_addr(bus_addr),
    .cmp_a_addr(cmp_a_addr), .cmp_b_addr(cmp_b_addr), .cmp_a_hit(cmp_a_hit),
    .cmp_b_hit(cmp_b_hit), .opc_a_exec(opc_a_exec), .opc_b_exec(opc_b_exec),
    .cap_valid(cap_valid), .cap_data(cap_data), .trace_armed(trace_armed), .irq(irq));
  dts_host_model host (.core_clk(core_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hang(hang));
  // Verdict and end of run
  task automatic wrap_up;
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // A bus wait that ran out ends the run
  always @(posedge hang) begin
    mismatches++;
    wrap_up();
  end
  // Byte compare
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  // Flag compare
  task automatic cmp1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  // One cycle of monitor inputs: bit0 A, 1 B, 2 A exec, 3 B exec, 4 bus, 5 capture
  task automatic tick(input logic [7:0] h, input logic [15:0] adr, input logic [15:0] cd);
    cmp_a_hit <= h[0];
    cmp_b_hit <= h[1];
    opc_a_exec <= h[2];
    opc_b_exec <= h[3];
    bus_valid <= h[4];
    cap_valid <= h[5];
    bus_addr <= adr;
    cap_data <= cd;
    @(posedge core_clk);
  endtask : tick
  // Quiet cycles
  task automatic idle(input int n);
    repeat (n) tick(8'h00, 16'h0000, 16'h0000);
  endtask : idle
  // Status register against expectation
  task automatic chk_status(input logic [7:0] exp);
    host.rd(OFS_RUN_STAT, rv);
    cmp8(rv, exp);
  endtask : chk_status
  // Configure while unarmed, then arm
  task automatic run(input logic [7:0] cfg);
    host.wr(OFS_CTRL, 8'h80);
    host.wr(OFS_TRIG_CFG, cfg);
    host.wr(OFS_CTRL, 8'hc0);
    model_q.delete();
  endtask : run
  // Read every expected word, high byte twice, then low
  task automatic drain;
    int base;
    base = host.fifo_reads;
    foreach (model_q[i]) begin
      host.rd(OFS_FIFO_HI, rv);
      cmp8(rv, 8'(model_q[i] >> 8));
      host.rd(OFS_FIFO_HI, rv);
      cmp8(rv, 8'(model_q[i] >> 8));
      host.rd(OFS_FIFO_LO, rv);
      cmp8(rv, 8'(model_q[i]));
    end
    // The host's own tally of words taken must meet the captured count
    host.rd(OFS_RUN_STAT, rv);
    cmp8(8'(host.fifo_reads - base), {4'h0, rv[3:0]});
  endtask : drain
  // Main sequence
  initial begin
    seed_v = $urandom(32'h1523);
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    // Reset values, hard-wired bits, read-only status, unmapped place
    chk_status(8'h00);
    host.wr(OFS_TRIG_CFG, 8'hff);
    host.rd(OFS_TRIG_CFG, rv);
    cmp8(rv, 8'hcf);
    host.wr(OFS_RUN_STAT, 8'hff);
    chk_status(8'h00);
    host.rd(5'h1c, rv);
    cmp8(rv, 8'h00);
    // End trace that wraps the store, config locked while armed
    run(8'h00);
    host.wr(OFS_TRIG_CFG, 8'h41);
    host.rd(OFS_TRIG_CFG, rv);
    cmp8(rv, 8'h00);
    chk_status(8'h20);
    for (int i = 0; i < 11; i++) begin
      wv = 16'($urandom);
      model_q.push_back(wv);
      if (model_q.size() > FIFO_DEPTH) void'(model_q.pop_front());
      tick(8'h20, 16'h0000, wv);
    end
    tick(8'h01, 16'h0000, 16'h0000);
    idle(3);
    chk_status(8'h88);
    drain();
    chk_status(8'h88);
    // Begin trace: only words after the trigger, ends when full
    run(8'h40);
    tick(8'h20, 16'h0000, 16'h1234);
    tick(8'h01, 16'h0000, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      wv = 16'($urandom);
      if (model_q.size() < FIFO_DEPTH) model_q.push_back(wv);
      tick(8'h20, 16'h0000, wv);
    end
    idle(3);
    chk_status(8'h88);
    drain();
    // Event-only with begin bit clear still runs as a begin trace
    run(8'h03);
    for (int i = 0; i < 8; i++) begin
      wv = 16'($urandom);
      model_q.push_back(wv & 16'h00ff);
      tick(8'h22, 16'h0000, wv);
      idle(1);
    end
    idle(3);
    chk_status(8'h48);
    drain();
    // Every mode code against a fixed stimulus order, then a manual stop
    for (int m = 0; m < 16; m++) begin
      run({4'h0, 4'(m)});
      for (int s = 0; s < 6; s++) begin
        tick(step_hits[s], (s == 4) ? cmp_a_addr : ((s == 5) ? cmp_b_addr + 16'h0001 :
             16'h0000), 16'h0000);
        idle(4);
        cmp1(trace_armed, ends_at[m] == 0 || s + 1 < ends_at[m]);
      end
      host.wr(OFS_CTRL, m[0] ? 8'h40 : 8'h80);
      idle(3);
      cmp1(trace_armed, 1'b0);
    end
    // Opcode qualification: a hit alone does not trigger
    run(8'h80);
    tick(8'h01, 16'h0000, 16'h0000);
    idle(4);
    cmp1(trace_armed, 1'b1);
    tick(8'h05, 16'h0000, 16'h0000);
    tick(8'h04, 16'h0000, 16'h0000);
    idle(4);
    cmp1(trace_armed, 1'b0);
    // Interrupt: masked, unmasked, cleared by writing ones
    cmp1(irq, 1'b0);
    host.wr(OFS_IRQ_MASK, 8'h01);
    idle(2);
    cmp1(irq, 1'b1);
    host.wr(OFS_IRQ_STAT, 8'h03);
    host.rd(OFS_IRQ_STAT, rv);
    cmp8(rv, 8'h00);
    idle(2);
    cmp1(irq, 1'b0);
    wrap_up();
  end
endmodule : debug_trigger_status_control_tb
